/* File: pkg/sfcp_consts.vh */
`ifndef SFCP_CONSTS_VH
`define SFCP_CONSTS_VH
`define SFCP_OP_WRITE_ENABLE   8'h06
`define SFCP_OP_WRITE_DISABLE  8'h04
`define SFCP_OP_READ_STATUS    8'h05
`define SFCP_OP_WRITE_STATUS   8'h01
`define SFCP_OP_JEDEC_ID       8'h9F
`define SFCP_OP_SIGNATURE      8'hAB
`define SFCP_OP_MAKER_DEVICE   8'h90
`define SFCP_OP_READ           8'h03
`define SFCP_OP_FAST_READ      8'h0B
`define SFCP_OP_DUAL_OUT_READ  8'h3B
`define SFCP_OP_DUAL_IO_READ   8'hBB
`define SFCP_OP_QUAD_OUT_READ  8'h6B
`define SFCP_OP_QUAD_IO_READ   8'hEB
`define SFCP_OP_QUAD_DTR_READ  8'hED
`define SFCP_OP_PAGE_PROGRAM   8'h02
`define SFCP_OP_QUAD_PROGRAM   8'h38
`define SFCP_OP_SECTOR_ERASE   8'h20
`define SFCP_OP_BLOCK32_ERASE  8'h52
`define SFCP_OP_BLOCK64_ERASE  8'hD8
`define SFCP_OP_CHIP_ERASE     8'h60
`define SFCP_OP_DEEP_POWERDOWN 8'hB9
`define SFCP_OP_OTP_ENTER      8'hB1
`define SFCP_OP_OTP_EXIT       8'hC1
`define SFCP_OP_READ_SECURITY  8'h2B
`define SFCP_OP_WRITE_SECURITY 8'h2F
`define SFCP_OP_RESET_ENABLE   8'h66
`define SFCP_OP_RESET          8'h99
// identification values are arbitrary
`define SFCP_MAKER_ID          8'h5A
`define SFCP_DEVICE_ID_HI      8'h31
`define SFCP_DEVICE_ID_LO      8'h18
`define SFCP_SIGNATURE_ID      8'h17
`define SFCP_DUMMY_SINGLE      4'h8
`define SFCP_DUMMY_DUAL_IO     4'h4
`define SFCP_DUMMY_QUAD_IO     4'h6
`define SFCP_MASK_SECTOR       24'h000FFF
`define SFCP_MASK_BLOCK32      24'h007FFF
`define SFCP_MASK_BLOCK64      24'h00FFFF
`define SFCP_MASK_CHIP         24'hFFFFFF
`define SFCP_ERASED_BYTE       8'hFF
`define SFCP_ADDR_BITS         5'h18
`define SFCP_PAGE_FULL         9'h100
`define SFCP_SYNC_RESET        8'h60
`endif

/* File: hw/sfcp_top.v */
`timescale 1ns/1ps
`include "sfcp_consts.vh"

module sfcp_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// system
	input  wire             clock_i,
	input  wire             srst_i,
	// fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	// depth must be a power of two; one spare pointer bit tells full from empty
	localparam [AW:0] FULL = DEPTH;
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wr_ptr;
	reg  [AW:0]      rd_ptr;
	wire [AW:0]      fill = wr_ptr - rd_ptr;
	assign in_ready_o  = (fill != FULL);
	assign out_valid_o = (fill != {(AW+1){1'b0}});
	assign out_data_o  = mem[rd_ptr[AW-1:0]];
	always @(posedge clock_i) begin
		if (in_valid_i && in_ready_o)
			mem[wr_ptr[AW-1:0]] <= in_data_i;
	end
	always @(posedge clock_i) begin
		if (srst_i) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else begin
			if (in_valid_i && in_ready_o)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_valid_o && out_ready_i)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // sfcp_fifo

module sfcp_top (
	// system
	input  wire        clock_i,
	input  wire        srst_i,
	// serial pins
	input  wire        cs_n_i,
	input  wire        sclk_i,
	input  wire [3:0]  io_line_i,
	output wire [3:0]  io_line_o,
	output wire [3:0]  io_line_oe_n_o,
	input  wire        hw_reset_n_i,
	// straps and configuration
	input  wire        factory_lock_i,
	input  wire [3:0]  dummy_cfg_i,
	// status
	output wire        write_in_progress_o,
	output wire        write_enable_latch_o,
	output wire        deep_powerdown_o,
	output wire        otp_mode_o,
	output wire        standby_o,
	output wire        cmd_reject_o,
	// array program port
	output wire        array_wr_valid_o,
	input  wire        array_wr_ready_i,
	output wire [23:0] array_wr_addr_o,
	output wire [7:0]  array_wr_data_o,
	// array erase port
	output wire        array_erase_req_o,
	output wire [23:0] array_erase_addr_o,
	output wire [23:0] array_erase_last_o,
	input  wire        array_erase_done_i,
	// array read port
	output wire [23:0] array_rd_addr_o,
	input  wire [7:0]  array_rd_data_i
);
	localparam FE_CMD = 3'h0, FE_ADDR = 3'h1, FE_DUMMY = 3'h2, FE_DIN = 3'h3;
	localparam FE_DOUT = 3'h4, FE_DONE = 3'h5, FE_IGNORE = 3'h6;
	localparam SQ_IDLE = 3'h0, SQ_PUSH = 3'h1, SQ_DRAIN = 3'h2, SQ_VERIFY = 3'h3;
	localparam SQ_ERASE = 3'h4, SQ_EVER = 3'h5;

	// pin synchronisers: {factory, hw reset, cs, sclk, io[3:0]}
	reg  [7:0] sync1;
	reg  [7:0] sync2;
	reg        sclk_d;
	reg        cs_d;
	always @(posedge clock_i) begin
		if (srst_i) begin
			sync1  <= `SFCP_SYNC_RESET;
			sync2  <= `SFCP_SYNC_RESET;
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sync1  <= {factory_lock_i, hw_reset_n_i, cs_n_i, sclk_i, io_line_i};
			sync2  <= sync1;
			sclk_d <= sync2[4];
			cs_d   <= sync2[5];
		end
	end
	wire [3:0] io_s    = sync2[3:0];
	wire       sel     = ~sync2[5];
	wire       rise    = sel && sync2[4] && !sclk_d;
	wire       fall    = sel && !sync2[4] && sclk_d;
	wire       cs_rise = sync2[5] && !cs_d;
	wire       fac_s   = sync2[7];

	// front end registers
	reg  [2:0]  fe_state;
	reg  [23:0] shreg;
	reg  [4:0]  bit_cnt;
	reg  [7:0]  opcode;
	reg  [3:0]  dummy_left;
	reg  [8:0]  got_bytes;
	reg  [23:0] cmd_addr;
	reg  [7:0]  out_sh;
	reg  [3:0]  out_left;
	reg  [1:0]  out_idx;
	reg  [3:0]  io_q;
	reg  [7:0]  status_wr;
	reg  [7:0]  page_buf [0:255];
	reg  [7:0]  otp_mem [0:511];
	// device state
	reg         latch;
	reg         dp;
	reg         otp_mode;
	reg  [3:0]  level;
	reg         tb;
	reg         cust_lock;
	reg         prog_fail;
	reg         erase_fail;
	reg         rst_armed;
	reg         reject_q;
	reg  [23:0] rd_addr;
	// sequencer
	reg  [2:0]  sq_state;
	reg  [23:0] sq_base;
	reg  [23:0] sq_idx;
	reg  [23:0] sq_last;
	reg  [8:0]  sq_count;
	reg         sq_ph;
	reg         sq_otp;

	// decode of the opcode being captured or held
	wire [7:0] dec_op = (fe_state == FE_CMD) ? {shreg[6:0], io_s[0]} : opcode;
	reg        d_addr;
	reg  [2:0] d_aw;
	reg        d_ddr;
	reg  [3:0] d_dummy;
	reg  [1:0] d_dir;
	reg  [2:0] d_dw;
	wire [3:0] dflt = (dummy_cfg_i != 4'h0) ? dummy_cfg_i : `SFCP_DUMMY_SINGLE;
	always @* begin
		d_addr  = 1'b0;
		d_aw    = 3'h1;
		d_ddr   = 1'b0;
		d_dummy = 4'h0;
		d_dir   = 2'h0;
		d_dw    = 3'h1;
		case (dec_op)
			`SFCP_OP_READ: begin
				d_addr = 1'b1; d_dir = 2'h1;
			end
			`SFCP_OP_FAST_READ: begin
				d_addr = 1'b1; d_dir = 2'h1; d_dummy = dflt;
			end
			`SFCP_OP_DUAL_OUT_READ: begin
				d_addr = 1'b1; d_dir = 2'h1; d_dummy = dflt; d_dw = 3'h2;
			end
			`SFCP_OP_QUAD_OUT_READ: begin
				d_addr = 1'b1; d_dir = 2'h1; d_dummy = dflt; d_dw = 3'h4;
			end
			`SFCP_OP_DUAL_IO_READ: begin
				d_addr = 1'b1; d_aw = 3'h2; d_dir = 2'h1; d_dw = 3'h2;
				d_dummy = (dummy_cfg_i != 4'h0) ? dummy_cfg_i : `SFCP_DUMMY_DUAL_IO;
			end
			`SFCP_OP_QUAD_IO_READ, `SFCP_OP_QUAD_DTR_READ: begin
				d_addr = 1'b1; d_aw = 3'h4; d_dir = 2'h1; d_dw = 3'h4;
				d_ddr = (dec_op == `SFCP_OP_QUAD_DTR_READ);
				d_dummy = (dummy_cfg_i != 4'h0) ? dummy_cfg_i : `SFCP_DUMMY_QUAD_IO;
			end
			`SFCP_OP_READ_STATUS, `SFCP_OP_READ_SECURITY, `SFCP_OP_JEDEC_ID: d_dir = 2'h1;
			`SFCP_OP_SIGNATURE, `SFCP_OP_MAKER_DEVICE: begin
				d_addr = 1'b1; d_dir = 2'h1;
			end
			`SFCP_OP_WRITE_STATUS: d_dir = 2'h2;
			`SFCP_OP_PAGE_PROGRAM: begin
				d_addr = 1'b1; d_dir = 2'h2;
			end
			`SFCP_OP_QUAD_PROGRAM: begin
				d_addr = 1'b1; d_aw = 3'h4; d_dir = 2'h2; d_dw = 3'h4;
			end
			`SFCP_OP_SECTOR_ERASE, `SFCP_OP_BLOCK32_ERASE, `SFCP_OP_BLOCK64_ERASE:
				d_addr = 1'b1;
			default: d_addr = 1'b0;
		endcase
	end

	// input stepping; double rate only moves address on the falling edge too
	wire       busy  = (sq_state != SQ_IDLE);
	wire [2:0] in_w  = (fe_state == FE_ADDR) ? d_aw : (fe_state == FE_DIN) ? d_dw : 3'h1;
	wire       in_ev = rise || (fall && d_ddr && fe_state == FE_ADDR);
	reg  [23:0] next_sh;
	always @* begin
		case (in_w)
			3'h2:    next_sh = {shreg[21:0], io_s[1:0]};
			3'h4:    next_sh = {shreg[19:0], io_s[3:0]};
			default: next_sh = {shreg[22:0], io_s[0]};
		endcase
	end
	wire [4:0] next_cnt  = bit_cnt + {2'b00, in_w};
	wire       addr_done = in_ev && fe_state == FE_ADDR && next_cnt == `SFCP_ADDR_BITS;
	wire       byte_in   = in_ev && fe_state == FE_DIN && next_cnt == 5'h08;
	wire       out_ev    = fe_state == FE_DOUT && (fall || (rise && d_ddr));
	wire       from_arr  = dec_op != `SFCP_OP_READ_STATUS && dec_op != `SFCP_OP_READ_SECURITY &&
	                       dec_op != `SFCP_OP_JEDEC_ID && dec_op != `SFCP_OP_SIGNATURE &&
	                       dec_op != `SFCP_OP_MAKER_DEVICE;
	wire       consume   = out_ev && out_left == 4'h0;
	wire       allowed   = !dp || dec_op == `SFCP_OP_SIGNATURE ||
	                       dec_op == `SFCP_OP_RESET_ENABLE || dec_op == `SFCP_OP_RESET;
	wire [7:0] buf_idx   = cmd_addr[7:0] + got_bytes[7:0];

	// output byte sources
	wire [7:0] status  = {tb, 1'b1, level, latch, busy};
	wire [7:0] secur   = {1'b0, erase_fail, prog_fail, 3'h0, cust_lock, fac_s};
	wire [7:0] mem_byte = otp_mode ? otp_mem[rd_addr[8:0]] : array_rd_data_i;
	reg  [7:0] src_byte;
	always @* begin
		case (dec_op)
			`SFCP_OP_READ_STATUS:   src_byte = status;
			`SFCP_OP_READ_SECURITY: src_byte = secur;
			`SFCP_OP_JEDEC_ID:
				src_byte = (out_idx == 2'h0) ? `SFCP_MAKER_ID :
				           (out_idx == 2'h1) ? `SFCP_DEVICE_ID_HI : `SFCP_DEVICE_ID_LO;
			`SFCP_OP_SIGNATURE:     src_byte = `SFCP_SIGNATURE_ID;
			`SFCP_OP_MAKER_DEVICE:
				src_byte = (out_idx == 2'h0) ? `SFCP_MAKER_ID : `SFCP_DEVICE_ID_LO;
			default:                src_byte = mem_byte;
		endcase
	end
	wire [7:0] out_byte = (out_left == 4'h0) ? src_byte : out_sh;

	// soft reset and the hardware pin both clear the volatile state
	wire aligned  = (fe_state == FE_DONE || fe_state == FE_DIN) && bit_cnt[2:0] == 3'h0;
	wire done_cmd = cs_rise && aligned;
	wire soft_rst = done_cmd && dec_op == `SFCP_OP_RESET && rst_armed;
	wire vol_rst  = srst_i || !sync2[6] || soft_rst;

	always @(posedge clock_i) begin
		if (vol_rst || !sel) begin
			fe_state  <= FE_CMD;
			bit_cnt   <= 5'h00;
			shreg     <= 24'h000000;
			out_left  <= 4'h0;
			out_idx   <= 2'h0;
			if (vol_rst) begin
				opcode     <= 8'h00;
				dummy_left <= 4'h0;
				got_bytes  <= 9'h000;
				cmd_addr   <= 24'h000000;
				out_sh     <= 8'h00;
				io_q       <= 4'h0;
				status_wr  <= 8'h00;
			end
		end else begin
			if (in_ev && fe_state != FE_DOUT && fe_state != FE_DUMMY &&
			    fe_state != FE_IGNORE) begin
				shreg   <= next_sh;
				bit_cnt <= next_cnt;
			end
			case (fe_state)
				FE_CMD: if (in_ev && bit_cnt == 5'h07) begin
					opcode    <= dec_op;
					bit_cnt   <= 5'h00;
					got_bytes <= 9'h000;
					if ((busy && dec_op != `SFCP_OP_READ_STATUS) || !allowed)
						fe_state <= FE_IGNORE;
					else if (d_addr)
						fe_state <= FE_ADDR;
					else if (d_dir == 2'h1)
						fe_state <= FE_DOUT;
					else if (d_dir == 2'h2)
						fe_state <= FE_DIN;
					else
						fe_state <= FE_DONE;
				end
				FE_ADDR: if (addr_done) begin
					cmd_addr   <= next_sh;
					bit_cnt    <= 5'h00;
					dummy_left <= d_dummy;
					if (d_dummy != 4'h0)
						fe_state <= FE_DUMMY;
					else if (d_dir == 2'h1)
						fe_state <= FE_DOUT;
					else if (d_dir == 2'h2)
						fe_state <= FE_DIN;
					else
						fe_state <= FE_DONE;
				end
				FE_DUMMY: if (rise) begin
					dummy_left <= dummy_left - 4'h1;
					if (dummy_left == 4'h1)
						fe_state <= FE_DOUT;
				end
				FE_DIN: if (byte_in) begin
					bit_cnt <= 5'h00;
					if (got_bytes == 9'h000)
						status_wr <= next_sh[7:0];
					if (got_bytes != `SFCP_PAGE_FULL)
						got_bytes <= got_bytes + 9'h001;
				end
				FE_DOUT: if (out_ev) begin
					case (d_dw)
						3'h2:    io_q <= {2'b00, out_byte[7:6]};
						3'h4:    io_q <= out_byte[7:4];
						default: io_q <= {2'b00, out_byte[7], 1'b0};
					endcase
					out_sh   <= (d_dw == 3'h4) ? {out_byte[3:0], 4'h0} :
					            (d_dw == 3'h2) ? {out_byte[5:0], 2'h0} : {out_byte[6:0], 1'b0};
					out_left <= ((out_left == 4'h0) ? 4'h8 : out_left) - {1'b0, d_dw};
					if (consume && out_idx != 2'h3)
						out_idx <= out_idx + 2'h1;
				end
				default: fe_state <= fe_state;
			endcase
		end
	end

	// page buffer fills as bytes arrive; wraps within the page once, then every byte past 256 lands at the start offset
	always @(posedge clock_i) begin
		if (byte_in && (opcode == `SFCP_OP_PAGE_PROGRAM || opcode == `SFCP_OP_QUAD_PROGRAM))
			page_buf[buf_idx] <= next_sh[7:0];
	end

	// protection window per 64k block
	wire [8:0] blk   = {1'b0, cmd_addr[23:16]};
	wire [8:0] nblk  = (level == 4'h0) ? 9'h000 :
	                   (level > 4'h8) ? `SFCP_PAGE_FULL :
	                   (9'h001 << (level - 4'h1));
	wire       prot  = tb ? (blk < nblk) : (blk >= (`SFCP_PAGE_FULL - nblk));
	wire       is_ce = dec_op == `SFCP_OP_CHIP_ERASE;
	wire       is_prog  = dec_op == `SFCP_OP_PAGE_PROGRAM || dec_op == `SFCP_OP_QUAD_PROGRAM;
	wire       is_erase = dec_op == `SFCP_OP_SECTOR_ERASE || dec_op == `SFCP_OP_BLOCK32_ERASE ||
	                      dec_op == `SFCP_OP_BLOCK64_ERASE || is_ce;
	wire       is_wsr   = dec_op == `SFCP_OP_WRITE_STATUS;
	wire       is_wsec  = dec_op == `SFCP_OP_WRITE_SECURITY;
	wire       otp_lock = fac_s || cust_lock;
	// array changes only from a whole, enabled, unprotected command
	wire go_wsr   = done_cmd && is_wsr && got_bytes != 9'h000 && latch;
	wire go_prog  = done_cmd && is_prog && got_bytes != 9'h000 && latch &&
	                (otp_mode ? !otp_lock : !prot);
	wire go_erase = done_cmd && is_erase && latch && !otp_mode &&
	                !(is_ce ? (nblk != 9'h000) : prot);
	wire go_wsec  = done_cmd && is_wsec && latch;
	wire modify   = is_prog || is_erase || is_wsr || is_wsec;
	wire [23:0] emask = (dec_op == `SFCP_OP_SECTOR_ERASE) ? `SFCP_MASK_SECTOR :
	                    (dec_op == `SFCP_OP_BLOCK32_ERASE) ? `SFCP_MASK_BLOCK32 :
	                    (dec_op == `SFCP_OP_BLOCK64_ERASE) ? `SFCP_MASK_BLOCK64 : `SFCP_MASK_CHIP;

	always @(posedge clock_i) begin
		if (vol_rst) begin
			latch     <= 1'b0;
			dp        <= 1'b0;
			otp_mode  <= 1'b0;
			rst_armed <= 1'b0;
			reject_q  <= 1'b0;
		end else begin
			reject_q <= cs_rise && ((fe_state == FE_CMD && bit_cnt != 5'h00) ||
			            (fe_state != FE_CMD && fe_state != FE_IGNORE && modify &&
			             !(go_wsr || go_prog || go_erase || go_wsec)));
			if (done_cmd && dec_op == `SFCP_OP_WRITE_ENABLE)
				latch <= 1'b1;
			else if ((done_cmd && dec_op == `SFCP_OP_WRITE_DISABLE) || go_wsr || go_wsec ||
			         (busy && sq_state != SQ_PUSH && sq_state != SQ_ERASE &&
			          sq_ph && sq_idx == sq_last))
				latch <= 1'b0;
			if (done_cmd && dec_op == `SFCP_OP_DEEP_POWERDOWN)
				dp <= 1'b1;
			else if (cs_rise && dec_op == `SFCP_OP_SIGNATURE && fe_state != FE_CMD &&
			         fe_state != FE_IGNORE)
				dp <= 1'b0;
			if (done_cmd && dec_op == `SFCP_OP_OTP_ENTER)
				otp_mode <= 1'b1;
			else if (done_cmd && dec_op == `SFCP_OP_OTP_EXIT)
				otp_mode <= 1'b0;
			if (done_cmd)
				rst_armed <= (dec_op == `SFCP_OP_RESET_ENABLE);
		end
	end

	// protection and locks survive soft and pin resets
	always @(posedge clock_i) begin
		if (srst_i) begin
			level     <= 4'h0;
			tb        <= 1'b0;
			cust_lock <= 1'b0;
		end else begin
			if (go_wsr) begin
				level <= status_wr[5:2];
				tb    <= status_wr[7];
			end
			if (go_wsec)
				cust_lock <= 1'b1;
		end
	end

	// automatic program / erase with read-back verify
	wire [23:0] prog_addr = {sq_base[23:8], sq_base[7:0] + sq_idx[7:0]};
	wire [7:0]  prog_byte = page_buf[sq_base[7:0] + sq_idx[7:0]];
	wire        fifo_rdy;
	wire        fifo_out_v;
	wire        push_v  = sq_state == SQ_PUSH && !sq_otp;
	wire        push_ok = sq_state == SQ_PUSH && (sq_otp || fifo_rdy);
	always @(posedge clock_i) begin
		if (push_ok && sq_otp)
			otp_mem[prog_addr[8:0]] <= prog_byte;
	end
	always @(posedge clock_i) begin
		if (vol_rst) begin
			sq_state   <= SQ_IDLE;
			sq_base    <= 24'h000000;
			sq_idx     <= 24'h000000;
			sq_last    <= 24'h000000;
			sq_count   <= 9'h000;
			sq_ph      <= 1'b0;
			sq_otp     <= 1'b0;
			prog_fail  <= 1'b0;
			erase_fail <= 1'b0;
		end else begin
			case (sq_state)
				SQ_IDLE: begin
					sq_idx <= 24'h000000;
					sq_ph  <= 1'b0;
					sq_otp <= otp_mode;
					if (go_prog) begin
						sq_state  <= SQ_PUSH;
						sq_base   <= cmd_addr;
						sq_count  <= got_bytes;
						sq_last   <= {15'h0000, got_bytes - 9'h001};
						prog_fail <= 1'b0;
					end else if (go_erase) begin
						sq_state   <= SQ_ERASE;
						sq_base    <= cmd_addr & ~emask;
						sq_last    <= cmd_addr | emask;
						erase_fail <= 1'b0;
					end
				end
				SQ_PUSH: if (push_ok) begin
					sq_idx <= sq_idx + 24'h000001;
					if (sq_idx == sq_last) begin
						sq_state <= SQ_DRAIN;
						sq_idx   <= 24'h000000;
					end
				end
				SQ_DRAIN: if (!fifo_out_v)
					sq_state <= SQ_VERIFY;
				SQ_ERASE: if (array_erase_done_i) begin
					sq_state <= SQ_EVER;
					sq_idx   <= sq_base;
				end
				SQ_VERIFY, SQ_EVER: begin
					sq_ph <= !sq_ph;
					if (sq_ph) begin
						if (sq_state == SQ_VERIFY && mem_byte != prog_byte)
							prog_fail <= 1'b1;
						if (sq_state == SQ_EVER && mem_byte != `SFCP_ERASED_BYTE)
							erase_fail <= 1'b1;
						sq_idx <= sq_idx + 24'h000001;
						if (sq_idx == sq_last)
							sq_state <= SQ_IDLE;
					end
				end
				default: sq_state <= SQ_IDLE;
			endcase
		end
	end

	// one read address serves host reads and verify
	always @(posedge clock_i) begin
		if (srst_i)
			rd_addr <= 24'h000000;
		else if (sq_state == SQ_VERIFY)
			rd_addr <= prog_addr;
		else if (sq_state == SQ_EVER)
			rd_addr <= sq_idx;
		else if (addr_done)
			rd_addr <= next_sh;
		else if (consume && from_arr && !busy)
			rd_addr <= rd_addr + 24'h000001;
	end

	// array writes stall the sequencer when the fifo fills
	sfcp_fifo #(
		.WIDTH (32),
		.DEPTH (32),
		.AW    (5)
	) u_fifo (
		.clock_i     (clock_i),
		.srst_i      (vol_rst),
		.in_valid_i  (push_v),
		.in_ready_o  (fifo_rdy),
		.in_data_i   ({prog_addr, prog_byte}),
		.out_valid_o (fifo_out_v),
		.out_ready_i (array_wr_ready_i),
		.out_data_o  ({array_wr_addr_o, array_wr_data_o})
	);

	reg [3:0] oe_mask;
	always @* begin
		case (d_dw)
			3'h2:    oe_mask = 4'hC;
			3'h4:    oe_mask = 4'h0;
			default: oe_mask = 4'hD;
		endcase
	end
	assign io_line_o            = io_q;
	assign io_line_oe_n_o       = (sel && fe_state == FE_DOUT) ? oe_mask : 4'hF;
	assign write_in_progress_o  = busy;
	assign write_enable_latch_o = latch;
	assign deep_powerdown_o     = dp;
	assign otp_mode_o           = otp_mode;
	assign standby_o            = !sel && !busy;
	assign cmd_reject_o         = reject_q;
	assign array_wr_valid_o     = fifo_out_v;
	assign array_erase_req_o    = sq_state == SQ_ERASE;
	assign array_erase_addr_o   = sq_base;
	assign array_erase_last_o   = sq_last;
	assign array_rd_addr_o      = rd_addr;
endmodule // sfcp_top

/* File: verification/sfcp_top_checker.sv */
`timescale 1ns/1ps
module sfcp_top_checker (
	// system
	input wire        clock_i,
	input wire        srst_i,
	// pins and status
	input wire        cs_n_i,
	input wire [3:0]  io_line_oe_n_o,
	input wire        write_in_progress_o,
	input wire        write_enable_latch_o,
	input wire        standby_o,
	input wire        cmd_reject_o,
	// array ports
	input wire        array_wr_valid_o,
	input wire        array_wr_ready_i,
	input wire [23:0] array_wr_addr_o,
	input wire [7:0]  array_wr_data_o,
	input wire        array_erase_req_o,
	input wire [23:0] array_erase_addr_o,
	input wire [23:0] array_erase_last_o,
	input wire        array_erase_done_i
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (srst_i);
	// four samples high covers the two-stage pin synchroniser
	sequence s_cs_idle;
		cs_n_i [*4];
	endsequence
	sequence s_wr_stall;
		array_wr_valid_o && !array_wr_ready_i;
	endsequence
	property p_oe_idle; s_cs_idle |-> io_line_oe_n_o == 4'hF; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("pins driven while deselected");
	property p_standby; s_cs_idle ##0 !write_in_progress_o |-> standby_o; endproperty
	a_standby: assert property (p_standby) else $error("standby missing");
	property p_reject; cmd_reject_o |=> !cmd_reject_o; endproperty
	a_reject: assert property (p_reject) else $error("reject longer than one cycle");
	property p_erase_hold; array_erase_req_o && !array_erase_done_i |=> array_erase_req_o; endproperty
	a_erase_hold: assert property (p_erase_hold) else $error("erase request dropped early");
	property p_erase_busy; array_erase_req_o || array_wr_valid_o |-> write_in_progress_o; endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("array busy but flag low");
	property p_wr_hold;
		s_wr_stall |=> array_wr_valid_o && $stable(array_wr_addr_o) && $stable(array_wr_data_o);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write word changed while stalled");
	property p_align;
		array_erase_req_o |-> array_erase_addr_o[11:0] == 12'h000 && &array_erase_last_o[11:0];
	endproperty
	a_align: assert property (p_align) else $error("erase range not sector aligned");
	property p_latch; $rose(write_in_progress_o) |-> $past(write_enable_latch_o); endproperty
	a_latch: assert property (p_latch) else $error("operation began without latch");
endmodule // sfcp_top_checker

bind sfcp_top sfcp_top_checker sfcp_top_checker_i (.*);

/* File: verification/sfcp_array_model.sv */
`timescale 1ns/1ps
module sfcp_array_model (
	// system
	input  wire        clock_i,
	input  wire        stall_i,
	// program port
	input  wire        wr_valid_i,
	output wire        wr_ready_o,
	input  wire [23:0] wr_addr_i,
	input  wire [7:0]  wr_data_i,
	// erase and read ports
	input  wire        erase_req_i,
	input  wire [23:0] erase_addr_i,
	input  wire [23:0] erase_last_i,
	output reg         erase_done_o,
	input  wire [23:0] rd_addr_i,
	output reg  [7:0]  rd_data_o
);
	logic [7:0] mem [int];
	int         wait_n = 0;
	initial erase_done_o = 1'b0;
	assign wr_ready_o = !stall_i;
	// also re-evaluated each falling edge since writes do not wake a level list
	always @(rd_addr_i or negedge clock_i)
		rd_data_o = mem.exists(rd_addr_i) ? mem[rd_addr_i] : 8'hFF;
	always @(posedge clock_i) begin
		erase_done_o <= 1'b0;
		if (wr_valid_i && wr_ready_o)
			mem[wr_addr_i] = wr_data_i;
		if (erase_req_i && !erase_done_o && ++wait_n > 6) begin
			foreach (mem[k])
				if (k >= erase_addr_i && k <= erase_last_i)
					mem[k] = 8'hFF;
			wait_n = 0;
			erase_done_o <= 1'b1;
		end
	end
endmodule // sfcp_array_model

/* File: verification/sfcp_top_test.sv */
`timescale 1ns/1ps
`include "sfcp_consts.vh"
module sfcp_top_test;
	logic        clock_i = 0, srst_i = 1, cs_n_i = 1, sclk_i = 0, hw_reset_n_i = 1;
	logic        factory_lock_i = 0, m3 = 0, stall = 0;
	logic [3:0]  dummy_cfg_i = 4'h0, drv = 4'h0;
	logic [31:0] lf = 32'h45D3;
	logic [7:0]  rb, d, tx[$], rx[$], pv[3] = '{8'h84, 8'h04, 8'h24}, pe[3] = '{8'h00, 8'hFF, 8'h00};
	logic [23:0] pa;
	int          n_fail = 0, total_checks = 0, nrj = 0, w = 1, nw = 0;
	wire  [3:0]  io_line_o, io_line_oe_n_o;
	wire         write_in_progress_o, write_enable_latch_o, deep_powerdown_o, otp_mode_o;
	wire         standby_o, cmd_reject_o, array_wr_valid_o, array_wr_ready_i, array_erase_req_o;
	wire         array_erase_done_i;
	wire  [23:0] array_wr_addr_o, array_erase_addr_o, array_erase_last_o, array_rd_addr_o;
	wire  [7:0]  array_wr_data_o, array_rd_data_i;
	// host lines yield wherever the device enables its driver
	wire  [3:0]  io_line_i = (io_line_o & ~io_line_oe_n_o) | (drv & io_line_oe_n_o);
	sfcp_top sfcp_top_i (.*);
	sfcp_array_model sfcp_array_model_i (.clock_i(clock_i), .stall_i(stall),
		.wr_valid_i(array_wr_valid_o), .wr_ready_o(array_wr_ready_i),
		.wr_addr_i(array_wr_addr_o), .wr_data_i(array_wr_data_o),
		.erase_req_i(array_erase_req_o), .erase_addr_i(array_erase_addr_o),
		.erase_last_i(array_erase_last_o), .erase_done_o(array_erase_done_i),
		.rd_addr_i(array_rd_addr_o), .rd_data_o(array_rd_data_i));
	initial forever #10 clock_i = ~clock_i;
	always @(posedge clock_i) if (cmd_reject_o === 1'b1) nrj++;
	function [31:0] nx(input [31:0] v);
		nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function [7:0] st(input t, input [3:0] l, input w);
		st = {t, 1'b1, l, w, 1'b0};
	endfunction
	task chk(input string nm, input [7:0] got, input [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task sb(input logic b, input int cw);
		lf = nx(lf);
		sclk_i = 0;
		drv = {lf[3:1], b};
		stall = lf[9];
		repeat (4) @(negedge clock_i);
		rb = (cw == 4) ? {rb[3:0], io_line_o} : (cw == 2) ? {rb[5:0], io_line_o[1:0]} :
		     {rb[6:0], io_line_o[1]};
		sclk_i = 1;
		repeat (4) @(negedge clock_i);
	endtask
	task go(input int nb);
		int k;
		rx = {};
		k = 0;
		// clock must settle at its idle level before select falls
		sclk_i = m3;
		repeat (2) @(negedge clock_i);
		cs_n_i = 0;
		repeat (2) @(negedge clock_i);
		for (int i = 0; i < nb; i++) begin
			sb(i / 8 < tx.size() ? tx[i / 8][7 - i % 8] : 1'b0, i < nw ? 1 : w);
			k += i < nw ? 1 : w;
			if (k % 8 == 0) rx.push_back(rb);
		end
		sclk_i = m3;
		repeat (2) @(negedge clock_i);
		cs_n_i = 1;
		repeat (12) @(negedge clock_i);
	endtask
	task wgo(input int nb);
		logic [7:0] t[$];
		t = tx;
		tx = '{8'h06};
		go(8);
		tx = t;
		go(nb);
	endtask
	task poll;
		for (int i = 0; i < 300; i++) begin
			tx = '{8'h05};
			go(16);
			if (rx[1][0] === 1'b0) return;
		end
		chk("poll_timeout", 8'h01, 8'h00);
		stop_test;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clock_i);
		srst_i = 0;
		repeat (4) @(negedge clock_i);
		chk("standby", standby_o, 1);
		m3 = 1;
		tx = '{8'h05};
		go(16);
		chk("status_mode3", rx[1], st(0, 0, 0));
		m3 = 0;
		tx = '{8'h9F};
		go(32);
		chk("jedec0", rx[1], `SFCP_MAKER_ID);
		chk("jedec1", rx[2], `SFCP_DEVICE_ID_HI);
		chk("jedec2", rx[3], `SFCP_DEVICE_ID_LO);
		tx = '{8'h90};
		go(48);
		chk("rems0", rx[4], `SFCP_MAKER_ID);
		chk("rems1", rx[5], `SFCP_DEVICE_ID_LO);
		pa = {1'b1, lf[22:1], 1'b0};
		d = lf[31:24];
		tx = '{8'h02, pa[23:16], pa[15:8], pa[7:0], d, ~d};
		go(48);
		chk("no_latch", nrj[7:0], 8'h01);
		wgo(48);
		poll;
		chk("latch_clear", write_enable_latch_o, 0);
		tx = '{8'h03, pa[23:16], pa[15:8], pa[7:0]};
		go(48);
		chk("read0", rx[4], d);
		chk("read1", rx[5], ~d);
		dummy_cfg_i = 4'h4;
		tx[0] = 8'h0B;
		go(44);
		chk("dummy_cfg", rb, d);
		dummy_cfg_i = 4'h0;
		nw = 40;
		w = 2;
		tx[0] = 8'h3B;
		go(48);
		chk("dual_out", rx[6], ~d);
		w = 4;
		tx[0] = 8'h6B;
		go(44);
		chk("quad_out", rx[6], ~d);
		w = 1;
		nw = 0;
		go(5);
		chk("partial", nrj[7:0], 8'h02);
		foreach (pv[i]) begin
			tx = '{8'h01, pv[i]};
			wgo(16);
			tx = '{8'h05};
			go(16);
			chk("level", rx[1], st(pv[i][7], pv[i][5:2], 0));
			tx = '{8'h20, pe[i], 8'hF0 & pe[i], 8'h00};
			wgo(32);
			chk("protect", nrj[7:0], 8'h03 + i[7:0]);
		end
		tx = '{8'h01, 8'h00};
		wgo(16);
		tx = '{8'h20, pa[23:16], pa[15:8], pa[7:0]};
		wgo(32);
		poll;
		tx = '{8'h03, pa[23:16], pa[15:8], pa[7:0]};
		go(40);
		chk("erased", rx[4], `SFCP_ERASED_BYTE);
		factory_lock_i = 1;
		tx = '{8'h2B};
		go(16);
		chk("security", rx[1], 8'h01);
		tx = '{8'hB1};
		go(8);
		chk("otp_enter", otp_mode_o, 1);
		tx = '{8'h20, pa[23:16], pa[15:8], pa[7:0]};
		wgo(32);
		chk("otp_no_erase", nrj[7:0], 8'h06);
		tx = '{8'hC1};
		go(8);
		chk("otp_exit", otp_mode_o, 0);
		tx = '{8'h04};
		go(8);
		chk("write_disable", write_enable_latch_o, 0);
		tx = '{8'hB9};
		go(8);
		chk("powerdown", deep_powerdown_o, 1);
		tx = '{8'h06};
		go(8);
		chk("pd_ignore", write_enable_latch_o, 0);
		tx = '{8'hAB};
		go(40);
		chk("signature", rx[4], `SFCP_SIGNATURE_ID);
		chk("wake", deep_powerdown_o, 0);
		tx = '{8'hB9};
		go(8);
		tx = '{8'h66};
		go(8);
		tx = '{8'h99};
		go(8);
		chk("pd_soft_reset", deep_powerdown_o, 0);
		tx = '{8'h06};
		go(8);
		hw_reset_n_i = 0;
		repeat (6) @(negedge clock_i);
		hw_reset_n_i = 1;
		repeat (4) @(negedge clock_i);
		chk("hw_reset", write_enable_latch_o, 0);
		stop_test;
	end
endmodule // sfcp_top_test
